//--- src/rcf_frame_parser.sv
// Purpose: hunts, frames and checks host command packets, dispatches them
// Assumes: rx bytes come from logic on sys_clk; executor answers with cmdDone
// Notes:   compact variant is the default after reset
// How it works
// - two variants, compact one selected after reset.
// - legacy packets open with AA and close with FF FF.
// - compact packets open with 02 02 and close with 03.
// - legacy packets never carry or get a checksum check.
// - incoming bytes are buffered; start sequence hunted first.
// - after start, find terminator, check format, dispatch or error.
// - exactly one response for every accepted command.
// - response is start, echo, values, terminator of active variant.
// - compact packet: start, length, code, optional fields, terminator.
// - two-byte length counts code through payload only.
// - one command code byte follows the length field.
// - two-byte tag address where present.
// - two-byte transfer length where present.
// - two-byte timeout in ms, valid 0001 to FFFE.
// - payload is fill byte or bytes to write.
// - checksum byte before terminator only when checksum mode on.
// - checksum is FF minus sum from length to last parameter.

`timescale 1ns/100ps
module rcf_frame_parser #(
   parameter int DEPTH = rcf_pkg::BUF_DEPTH
) (
   input  wire logic        sys_clk,    // system clock
   input  wire logic        rst,        // async reset
   input  wire logic        legacyMode, // 1 selects legacy word variant
   input  wire logic        csumMode,   // compact checksum enable
   input  wire logic [7:0]  rxData,     // host byte
   input  wire logic        rxValid,    // host byte valid
   input  wire logic        cmdDone,    // executor finished
   input  wire logic [7:0]  cmdResult,  // executor result value
   input  wire logic        txReady,    // host takes response byte
   output logic             cmdValid,   // command dispatched pulse
   output logic      [7:0]  cmdCode,    // command code
   output logic      [15:0] cmdAddr,    // tag address
   output logic      [15:0] cmdXferLen, // transfer length
   output logic      [15:0] cmdTimeout, // timeout in ms
   output logic      [15:0] cmdPayLen,  // payload bytes in buffer
   output logic      [7:0]  frameErr,   // last error code
   output logic      [7:0]  txData,     // response byte
   output logic             txValid     // response byte valid
);
   import rcf_pkg::*;
   localparam int AW = $clog2(DEPTH);

   // -------------------------------------------------------------
   // state
   // -------------------------------------------------------------
   rcf_state_t  st_ff, nxt_st;
   logic        mode_ff, nxt_mode;
   logic [15:0] len_ff, nxt_len;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [7:0]  code_ff, nxt_code;
   logic [15:0] addr_ff, nxt_addr;
   logic [15:0] xlen_ff, nxt_xlen;
   logic [15:0] tmo_ff, nxt_tmo;
   logic        tail_ff, nxt_tail;
   logic        cv_ff, nxt_cv;
   logic [7:0]  err_ff, nxt_err;
   logic [AW:0] wp_ff, nxt_wp;
   logic [7:0]  pay [DEPTH];
   logic        csClr, csAdd, respGo, respBusy, payWr;
   logic [7:0]  csSum, respVal;

   // -------------------------------------------------------------
   // helpers
   // -------------------------------------------------------------
   rcf_csum u_csum (
      .sys_clk (sys_clk),
      .rst     (rst),
      .clr     (csClr),
      .add     (csAdd),
      .din     (rxData),
      .sum     (csSum)
   );

   rcf_resp_tx u_tx (
      .sys_clk (sys_clk),
      .rst     (rst),
      .go      (respGo),
      .legacy  (mode_ff),
      .echo    (code_ff),
      .value   (respVal),
      .txReady (txReady),
      .busy    (respBusy),
      .txData  (txData),
      .txValid (txValid)
   );

   function automatic logic is_start(input logic leg, input logic [7:0] b);
      is_start = leg ? (b == LEG_START) : (b == FAST_START);
   endfunction

   // -------------------------------------------------------------
   // payload buffer
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      if (payWr) begin
         pay[wp_ff[AW-1:0]] <= rxData;
      end
   end

   // -------------------------------------------------------------
   // framing state machine
   // -------------------------------------------------------------
   always_comb begin
      nxt_st   = st_ff;
      nxt_mode = mode_ff;
      nxt_len  = len_ff;
      nxt_cnt  = cnt_ff;
      nxt_code = code_ff;
      nxt_addr = addr_ff;
      nxt_xlen = xlen_ff;
      nxt_tmo  = tmo_ff;
      nxt_tail = tail_ff;
      nxt_cv   = 1'b0;
      nxt_err  = err_ff;
      nxt_wp   = wp_ff;
      csClr    = 1'b0;
      csAdd    = 1'b0;
      respGo   = 1'b0;
      respVal  = cmdResult;
      payWr    = 1'b0;
      unique case (st_ff)
         ST_HUNT: begin
            nxt_mode = legacyMode;      // variant latched per packet
            csClr    = 1'b1;
            nxt_cnt  = 16'h0000;
            nxt_wp   = '0;
            if (rxValid && is_start(legacyMode, rxData)) begin
               // legacy has one start byte; compact needs a second
               nxt_st = legacyMode ? ST_BODY : ST_START;
               nxt_len = 16'hFFFF;
            end
         end
         ST_START: if (rxValid) begin
            nxt_st = (rxData == FAST_START) ? ST_LENHI : ST_HUNT;
         end
         ST_LENHI: if (rxValid) begin
            csAdd = 1'b1;
            nxt_len = {rxData, 8'h00};
            nxt_st = ST_LENLO;
         end
         ST_LENLO: if (rxValid) begin
            csAdd = 1'b1;
            nxt_len = {len_ff[15:8], rxData};
            nxt_st = ({len_ff[15:8], rxData} == 16'h0000) ? ST_HUNT : ST_BODY;
         end
         ST_BODY: if (rxValid) begin
            csAdd = 1'b1;
            nxt_cnt = cnt_ff + 16'h0001;
            // legacy: first FF after the code byte ends the body; checksum never used
            if (mode_ff && rxData == LEG_TERM && cnt_ff != 16'h0000) begin
               nxt_st = ST_TAIL;
               nxt_tail = 1'b0;
            end else begin
               // the first terminator byte is neither a field nor payload
               unique case (cnt_ff)
                  16'h0000: nxt_code = rxData;
                  POS_ADDR: nxt_addr[15:8] = rxData;
                  16'h0002: nxt_addr[7:0]  = rxData;
                  POS_XLEN: nxt_xlen[15:8] = rxData;
                  16'h0004: nxt_xlen[7:0]  = rxData;
                  POS_TMO:  nxt_tmo[15:8]  = rxData;
                  16'h0006: nxt_tmo[7:0]   = rxData;
                  default: begin
                     if (wp_ff < (AW+1)'(DEPTH)) begin
                        nxt_wp = wp_ff + 1'b1;
                        payWr  = 1'b1;
                     end
                  end
               endcase
            end
            if (!mode_ff && nxt_cnt == len_ff) begin
               nxt_st = ST_TAIL;
               nxt_tail = !csumMode;    // checksum byte expected first
            end
         end
         ST_TAIL: if (rxValid) begin
            if (mode_ff) begin
               // second FF completes a legacy frame
               nxt_st = (rxData == LEG_TERM) ? ST_WAIT : ST_HUNT;
            end else if (!tail_ff) begin
               csAdd = 1'b1;
               nxt_tail = 1'b1;
            end else begin
               nxt_st = (rxData == FAST_TERM) ? ST_WAIT : ST_HUNT;
            end
            if (nxt_st == ST_WAIT) begin
               // format check: checksum then timeout range
               if (!mode_ff && csumMode && csSum != CSUM_TARGET) begin
                  nxt_err = ERR_CSUM;
                  nxt_st  = ST_HUNT;    // discard and resume
               end else if (cnt_ff >= POS_DATA &&
                            (tmo_ff < TMO_MIN || tmo_ff > TMO_MAX)) begin
                  nxt_err = ERR_TIMEOUT;
                  respVal = ERR_TIMEOUT;
                  respGo  = !respBusy;  // error response echoes command
                  nxt_st  = ST_HUNT;
               end else begin
                  nxt_err = ERR_NONE;
                  nxt_cv  = 1'b1;       // dispatch
               end
            end else if (nxt_st == ST_HUNT && !mode_ff && tail_ff) begin
               nxt_err = ERR_FORMAT;
            end
         end
         ST_WAIT: begin
            if (cmdDone && !respBusy) begin
               respGo = 1'b1;           // one response per command
               nxt_st = ST_HUNT;
            end
         end
         default: nxt_st = ST_HUNT;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         st_ff   <= ST_HUNT;
         mode_ff <= MODE_RESET;         // compact by default
         len_ff  <= 16'h0000;
         cnt_ff  <= 16'h0000;
         code_ff <= 8'h00;
         addr_ff <= 16'h0000;
         xlen_ff <= 16'h0000;
         tmo_ff  <= 16'h0000;
         tail_ff <= 1'b0;
         cv_ff   <= 1'b0;
         err_ff  <= ERR_NONE;
         wp_ff   <= '0;
      end else begin
         st_ff   <= nxt_st;
         mode_ff <= nxt_mode;
         len_ff  <= nxt_len;
         cnt_ff  <= nxt_cnt;
         code_ff <= nxt_code;
         addr_ff <= nxt_addr;
         xlen_ff <= nxt_xlen;
         tmo_ff  <= nxt_tmo;
         tail_ff <= nxt_tail;
         cv_ff   <= nxt_cv;
         err_ff  <= nxt_err;
         wp_ff   <= nxt_wp;
      end
   end

   assign cmdValid   = cv_ff;
   assign cmdCode    = code_ff;
   assign cmdAddr    = addr_ff;
   assign cmdXferLen = xlen_ff;
   assign cmdTimeout = tmo_ff;
   assign cmdPayLen  = {{(15-AW){1'b0}}, wp_ff};
   assign frameErr   = err_ff;

   // -------------------------------------------------------------
   // checks
   // -------------------------------------------------------------
   AST_RESET_MODE: assert property (@(posedge sys_clk) $fell(rst) |-> !mode_ff)
      else $error("mode not compact after reset");
   AST_ONE_RESP: assert property (@(posedge sys_clk) disable iff (rst)
      cmdValid |-> !respGo [*1] ##1 (st_ff == ST_WAIT))
      else $error("dispatch left wait state early");
   AST_CSUM_BAD: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == ST_TAIL && rxValid && !mode_ff && csumMode && tail_ff
       && rxData == FAST_TERM && csSum != CSUM_TARGET) |=> frameErr == ERR_CSUM)
      else $error("bad checksum not flagged");
   AST_LEG_NOCS: assert property (@(posedge sys_clk) disable iff (rst)
      (mode_ff && st_ff == ST_TAIL) |=> frameErr != ERR_CSUM || $stable(frameErr))
      else $error("checksum error in legacy variant");
   AST_HUNT_START: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == ST_HUNT && rxValid && !is_start(legacyMode, rxData)) |=> st_ff == ST_HUNT)
      else $error("left hunt without start byte");
   AST_FAST_2ND: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == ST_START && rxValid && rxData != FAST_START) |=> st_ff == ST_HUNT)
      else $error("single start byte accepted");
   AST_DISPATCH: assert property (@(posedge sys_clk) disable iff (rst)
      cmdValid |-> frameErr == ERR_NONE && st_ff == ST_WAIT)
      else $error("dispatch with error");
   AST_RESP_FRAME: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(txValid) |-> txData == LEG_START || txData == FAST_START)
      else $error("response does not open with start byte");
   AST_PAY_STORE: assert property (@(posedge sys_clk) disable iff (rst)
      payWr |=> pay[$past(wp_ff[AW-1:0])] == $past(rxData))
      else $error("payload byte not stored");
   AST_LEG_NOPAY: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == ST_BODY && rxValid && mode_ff && rxData == LEG_TERM && cnt_ff != 16'h0000)
      |=> st_ff == ST_TAIL && $stable(wp_ff))
      else $error("legacy terminator taken as payload");
   AST_TMO_RANGE: assert property (@(posedge sys_clk) disable iff (rst)
      (cmdValid && cnt_ff >= POS_DATA) |-> cmdTimeout >= TMO_MIN && cmdTimeout <= TMO_MAX)
      else $error("timeout out of range dispatched");
   AST_BAD_TERM: assert property (@(posedge sys_clk) disable iff (rst)
      (st_ff == ST_TAIL && rxValid && !mode_ff && tail_ff && rxData != FAST_TERM)
      |=> st_ff == ST_HUNT && frameErr == ERR_FORMAT)
      else $error("bad terminator not dropped");
   AST_RESP_VARIANT: assert property (@(posedge sys_clk) disable iff (rst)
      $rose(txValid) |-> txData == (mode_ff ? LEG_START : FAST_START))
      else $error("response start byte of wrong variant");
endmodule

//--- src/rcf_pkg.sv
// Purpose: constants shared by the command frame parser and its helpers
// Assumes: one byte-wide receive stream and one byte-wide response stream
// Notes:   framing bytes, field positions and timeout limits

package rcf_pkg;
   // -------------------------------------------------------------
   // framing bytes
   // -------------------------------------------------------------
   localparam logic [7:0]  FAST_START    = 8'h02;
   localparam logic [7:0]  FAST_TERM     = 8'h03;
   localparam logic [7:0]  LEG_START     = 8'hAA;
   localparam logic [7:0]  LEG_TERM      = 8'hFF;
   localparam logic [7:0]  CSUM_TARGET   = 8'hFF;
   // -------------------------------------------------------------
   // field positions within the body (after start and length)
   // -------------------------------------------------------------
   localparam logic [15:0] POS_ADDR      = 16'h0001;
   localparam logic [15:0] POS_XLEN      = 16'h0003;
   localparam logic [15:0] POS_TMO       = 16'h0005;
   localparam logic [15:0] POS_DATA      = 16'h0007;
   localparam logic [15:0] TMO_MIN       = 16'h0001;
   localparam logic [15:0] TMO_MAX       = 16'hFFFE;
   // -------------------------------------------------------------
   // error codes reported on frameErr; only a timeout error is also sent in a response
   // -------------------------------------------------------------
   localparam logic [7:0]  ERR_NONE      = 8'h00;
   localparam logic [7:0]  ERR_CSUM      = 8'h01;
   localparam logic [7:0]  ERR_FORMAT    = 8'h02;
   localparam logic [7:0]  ERR_TIMEOUT   = 8'h03;
   localparam logic        MODE_RESET    = 1'b0;
   localparam int          BUF_DEPTH     = 64;
   // -------------------------------------------------------------
   // types
   // -------------------------------------------------------------
   typedef enum logic [6:0] {
      ST_HUNT  = 7'b0000001,
      ST_START = 7'b0000010,
      ST_LENHI = 7'b0000100,
      ST_LENLO = 7'b0001000,
      ST_BODY  = 7'b0010000,
      ST_TAIL  = 7'b0100000,
      ST_WAIT  = 7'b1000000
   } rcf_state_t;
endpackage

//--- src/rcf_csum.sv
// Purpose: running modulo-256 sum over the checked span of a packet
// Assumes: clear and add never both matter in one cycle; clear wins
// Notes:   sum goes to the parser, which compares it with the target

`timescale 1ns/100ps
module rcf_csum (
   input  wire logic       sys_clk,   // system clock
   input  wire logic       rst,       // async reset
   input  wire logic       clr,       // restart sum
   input  wire logic       add,       // add byte
   input  wire logic [7:0] din,       // byte to add
   output logic      [7:0] sum        // running sum
);
   import rcf_pkg::*;
   logic [7:0] sum_ff;
   logic [7:0] nxt_sum;

   always_comb begin
      nxt_sum = sum_ff;
      if (clr) begin
         nxt_sum = 8'h00;
      end else if (add) begin
         nxt_sum = sum_ff + din;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         sum_ff <= 8'h00;
      end else begin
         sum_ff <= nxt_sum;
      end
   end

   assign sum = sum_ff;
endmodule

//--- src/rcf_resp_tx.sv
// Purpose: frames one host-bound response: start, echo, values, terminator
// Assumes: host accepts a byte when txReady is high
// Notes:   one result byte is sent as the response value

`timescale 1ns/100ps
module rcf_resp_tx (
   input  wire logic       sys_clk,   // system clock
   input  wire logic       rst,       // async reset
   input  wire logic       go,        // start a response
   input  wire logic       legacy,    // framing variant
   input  wire logic [7:0] echo,      // command code echo
   input  wire logic [7:0] value,     // result or error code
   input  wire logic       txReady,   // host takes byte
   output logic            busy,      // response in flight
   output logic      [7:0] txData,    // response byte
   output logic            txValid    // response byte valid
);
   import rcf_pkg::*;
   logic [2:0] idx_ff, nxt_idx;
   logic       busy_ff, nxt_busy;
   logic       leg_ff, nxt_leg;
   logic [7:0] echo_ff, nxt_echo, val_ff, nxt_val, dat_ff, nxt_dat;
   logic [2:0] last;

   always_comb begin
      nxt_idx  = idx_ff;
      nxt_busy = busy_ff;
      nxt_leg  = leg_ff;
      nxt_echo = echo_ff;
      nxt_val  = val_ff;
      last     = leg_ff ? 3'd4 : 3'd4;
      if (!busy_ff && go) begin
         nxt_busy = 1'b1;
         nxt_idx  = 3'd0;
         nxt_leg  = legacy;
         nxt_echo = echo;
         nxt_val  = value;
      end else if (busy_ff && txReady) begin
         if (idx_ff == last) begin
            nxt_busy = 1'b0;
         end
         nxt_idx = idx_ff + 3'd1;
      end
      // legacy: AA echo val FF FF ; compact: 02 02 echo val 03
      unique case (nxt_idx)
         3'd0:    nxt_dat = nxt_leg ? LEG_START : FAST_START;
         3'd1:    nxt_dat = nxt_leg ? nxt_echo : FAST_START;
         3'd2:    nxt_dat = nxt_leg ? nxt_val : nxt_echo;
         3'd3:    nxt_dat = nxt_leg ? LEG_TERM : nxt_val;
         3'd4:    nxt_dat = nxt_leg ? LEG_TERM : FAST_TERM;
         default: nxt_dat = 8'h00;
      endcase
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         idx_ff  <= 3'd0;
         busy_ff <= 1'b0;
         leg_ff  <= 1'b0;
         echo_ff <= 8'h00;
         val_ff  <= 8'h00;
         dat_ff  <= 8'h00;
      end else begin
         idx_ff  <= nxt_idx;
         busy_ff <= nxt_busy;
         leg_ff  <= nxt_leg;
         echo_ff <= nxt_echo;
         val_ff  <= nxt_val;
         dat_ff  <= nxt_dat;
      end
   end

   assign busy    = busy_ff;
   assign txValid = busy_ff;
   assign txData  = dat_ff;
endmodule

//--- tb/rcf_host_model.sv
// Purpose: host side of the serial link: sends command bytes, reads responses
// Assumes: one byte per rxValid pulse; a response byte is taken when txReady is high
// Notes:   slow mode drops txReady at random to stall the response stream

`timescale 1ns/100ps
module rcf_host_model (
   input  wire logic       sys_clk,  // system clock
   input  wire logic       slow,     // stall response reads at random
   input  wire logic [7:0] txData,   // response byte
   input  wire logic       txValid,  // response byte valid
   output logic      [7:0] rxData,   // command byte
   output logic            rxValid,  // command byte valid
   output logic            txReady   // response byte taken
);
   logic [7:0] rsp [$];

   initial begin
      rxData = 8'h00;
      rxValid = 1'b0;
      txReady = 1'b1;
   end

   // each command byte is valid for one cycle, then the line idles one cycle
   task automatic send(input logic [7:0] q [$]);
      foreach (q[i]) begin
         @(negedge sys_clk);
         rxData = q[i];
         rxValid = 1'b1;
         @(negedge sys_clk);
         rxValid = 1'b0;
         // idle line never repeats the byte just sent
         rxData = ~q[i];
      end
   endtask

   always @(negedge sys_clk) txReady <= slow ? 1'($urandom_range(0, 1)) : 1'b1;

   always @(posedge sys_clk) begin
      if (txValid === 1'b1 && txReady === 1'b1) begin
         rsp.push_back(txData);
      end
   end
endmodule

//--- tb/tb_top.sv
// Purpose: self-checking bench for the command frame parser
// Assumes: bench plays the command executor; host model plays the link
// Notes:   expected fields and responses come from the packet builder below

`timescale 1ns/100ps
module tb_top;
   import rcf_pkg::*;
   logic        sys_clk, rst, legacyMode, csumMode, rxValid, cmdDone, txReady;
   logic        cmdValid, txValid, slow;
   logic [7:0]  rxData, cmdResult, cmdCode, frameErr, txData, eCode, cC;
   logic [15:0] cmdAddr, cmdXferLen, cmdTimeout, cmdPayLen;
   logic [15:0] eAddr, eXlen, eTmo, ePay, cA, cX, cT, cP, tm;
   logic [7:0]  pkt [$];
   logic [7:0]  codes [8] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h0D, 8'h0E, 8'h0F};
   logic [15:0] tmos [4] = '{16'h0000, 16'h0001, 16'hFFFE, 16'hFFFF};
   int          nFail, totalChecks, nd, cyc;

   rcf_frame_parser DUT (.sys_clk(sys_clk), .rst(rst), .legacyMode(legacyMode),
      .csumMode(csumMode), .rxData(rxData), .rxValid(rxValid), .cmdDone(cmdDone),
      .cmdResult(cmdResult), .txReady(txReady), .cmdValid(cmdValid), .cmdCode(cmdCode),
      .cmdAddr(cmdAddr), .cmdXferLen(cmdXferLen), .cmdTimeout(cmdTimeout),
      .cmdPayLen(cmdPayLen), .frameErr(frameErr), .txData(txData), .txValid(txValid));
   rcf_host_model host (.sys_clk(sys_clk), .slow(slow), .txData(txData),
      .txValid(txValid), .rxData(rxData), .rxValid(rxValid), .txReady(txReady));

   initial begin
      sys_clk = 1'b0;
      forever #4 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 50000) begin
         nFail++;
         results();
      end
      if (cmdValid === 1'b1) begin
         nd++;
         cC = cmdCode;
         cA = cmdAddr;
         cX = cmdXferLen;
         cT = cmdTimeout;
         cP = cmdPayLen;
      end
   end

   // -------------------------------------------------------------
   // checking and packet building
   // -------------------------------------------------------------
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      totalChecks++;
      if (got !== exp) begin
         nFail++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic mkc(input logic [7:0] code, input logic [15:0] ad, xl, tmo, input int np);
      logic [7:0] b [$];
      logic [7:0] s;
      b = {code, ad[15:8], ad[7:0], xl[15:8], xl[7:0], tmo[15:8], tmo[7:0]};
      repeat (np) b.push_back(8'($urandom_range(0, 255)));
      eCode = code;
      eAddr = ad;
      eXlen = xl;
      eTmo = tmo;
      ePay = 16'(np);
      if (legacyMode) begin
         pkt = {LEG_START, b, LEG_TERM, LEG_TERM};
         return;
      end
      s = 8'(b.size() >> 8) + 8'(b.size());
      foreach (b[i]) s += b[i];
      pkt = {FAST_START, FAST_START, 8'(b.size() >> 8), 8'(b.size()), b};
      if (csumMode) pkt.push_back(CSUM_TARGET - s);
      pkt.push_back(FAST_TERM);
   endtask

   // kind 0 checksum drop, 1 dispatch, 2 timeout error reply, 3 silent drop
   task automatic xfer(input int kind);
      int         nd0, i;
      logic [7:0] rv;
      logic [7:0] ex [$];
      nd0 = nd;
      host.rsp = {};
      rv = (kind == 2) ? ERR_TIMEOUT : 8'($urandom_range(0, 255));
      host.send(pkt);
      for (i = 0; i < 20 && nd == nd0; i++) @(negedge sys_clk);
      chk(16'(nd - nd0), 16'(kind == 1));
      if (kind == 1) begin
         chk(cC, eCode);
         chk(cA, eAddr);
         chk(cX, eXlen);
         chk(cT, eTmo);
         chk(cP, ePay);
         repeat ($urandom_range(0, 4)) @(negedge sys_clk);
         cmdResult = rv;
         cmdDone = 1'b1;
         @(negedge sys_clk);
         cmdDone = 1'b0;
      end
      if (kind == 1 || kind == 2) begin
         ex = {FAST_START, FAST_START, eCode, rv, FAST_TERM};
         if (legacyMode) ex = {LEG_START, eCode, rv, LEG_TERM, LEG_TERM};
      end
      for (i = 0; i < 300 && host.rsp.size() < ex.size(); i++) @(negedge sys_clk);
      repeat (20) @(negedge sys_clk);
      chk(16'(host.rsp.size()), 16'(ex.size()));
      foreach (ex[k]) chk(host.rsp[k], ex[k]);
      if (kind == 0) chk(frameErr, ERR_CSUM);
      if (kind == 1) chk(frameErr, ERR_NONE);
      if (kind == 2) chk(frameErr, ERR_TIMEOUT);
      if (kind == 3) chk(frameErr, ERR_FORMAT);
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", totalChecks, nFail);
      if (nFail == 0 && totalChecks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // -------------------------------------------------------------
   // main sequence
   // -------------------------------------------------------------
   initial begin
      void'($urandom(38));
      rst = 1'b1;
      legacyMode = 1'b0;
      csumMode = 1'b1;
      cmdDone = 1'b0;
      cmdResult = 8'h00;
      slow = 1'b0;
      repeat (2) @(negedge sys_clk);
      rst = 1'b0;
      mkc(8'h05, 16'h0001, 16'h0004, 16'h07D0, 0);
      xfer(1);
      for (int i = 0; i < 8; i++) begin
         csumMode = i[0];
         slow = i[1];
         tm = 16'($urandom_range(1, 16'hFFFE));
         mkc(codes[i], 16'($urandom), 16'($urandom), tm, $urandom_range(0, 9));
         xfer(1);
      end
      foreach (tmos[i]) begin
         mkc(8'h06, 16'h0000, 16'h0001, tmos[i], 1);
         xfer((i == 0 || i == 3) ? 2 : 1);
      end
      csumMode = 1'b1;
      mkc(8'h04, 16'h0010, 16'h0002, 16'h0100, 1);
      pkt[pkt.size() - 2] ^= 8'h01;
      xfer(0);
      mkc(8'h07, 16'h0000, 16'h0000, 16'h0020, 0);
      pkt.push_front(8'h55);
      pkt.push_front(8'h02);
      pkt.push_front(LEG_START);
      xfer(1);
      csumMode = 1'b0;
      mkc(8'h08, 16'h0003, 16'h0000, 16'h0040, 2);
      pkt[pkt.size() - 1] = 8'h04;
      xfer(3);
      legacyMode = 1'b1;
      csumMode = 1'b1;
      for (int i = 0; i < 2; i++) begin
         tm = {8'($urandom_range(0, 254)), 8'($urandom_range(1, 254))};
         mkc(codes[i + 1], {8'($urandom_range(0, 254)), 8'h02}, 16'h0103, tm, 0);
         xfer(1);
      end
      legacyMode = 1'b0;
      mkc(8'h0E, 16'h0200, 16'h0008, 16'h07D0, 0);
      xfer(1);
      results();
   end
endmodule
